// [rtl/srs_pkg.sv]
// package for the switch route select control block
package srs_pkg;
   // register offsets on the serial control register port
   localparam logic [7:0] SRS_OFS_FAST_MODES  = 8'h00;
   localparam logic [7:0] SRS_OFS_SIDE_MODES  = 8'h01;
   localparam logic [7:0] SRS_OFS_RX_SETTINGS = 8'h10;
   localparam logic [7:0] SRS_OFS_TERM_PULSE1 = 8'h11;
   localparam logic [7:0] SRS_OFS_TERM_PULSE2 = 8'h12;

   // reset values
   localparam logic [7:0] SRS_RST_FAST_MODES  = 8'h40;
   localparam logic [7:0] SRS_RST_SIDE_MODES  = 8'h40;
   localparam logic [7:0] SRS_RST_RX_SETTINGS = 8'h01;
   localparam logic [7:0] SRS_RST_TERM_PULSE  = 8'h00;

   // field positions of the two modes registers, and the termination bit of the rx settings register
   localparam int SRS_ENABLE_BIT = 6;
   localparam int SRS_MODE_MSB   = 5;
   localparam int SRS_MODE_LSB   = 4;
   localparam int SRS_SRC_MSB    = 3;
   localparam int SRS_SRC_LSB    = 0;
   localparam int SRS_TERM_BIT   = 0;

   // writable bits; the rest read as zero
   localparam logic [7:0] SRS_MASK_MODES = 8'h7f;
   localparam logic [7:0] SRS_MASK_RX    = 8'h01;
   localparam logic [7:0] SRS_MASK_PULSE = 8'hff;

   // switching modes; the fourth code is illegal and never stored
   localparam logic [1:0] SRS_MODE_QUAD    = 2'h0;
   localparam logic [1:0] SRS_MODE_DUAL    = 2'h1;
   localparam logic [1:0] SRS_MODE_SINGLE  = 2'h2;
   localparam logic [1:0] SRS_MODE_ILLEGAL = 2'h3;

   localparam int SRS_LINES = 4;

   // register write/read request from the serial control decoder
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } srs_req_t;

   // auxiliary common line routing: channel index {source, channel} per line
   typedef struct packed {
      logic [SRS_LINES-1:0]      connect;
      logic [SRS_LINES-1:0][3:0] chanSel;
   } srs_side_route_t;

   // whole state of the block
   typedef struct packed {
      logic [7:0] fastModes;
      logic [7:0] sideModes;
      logic [7:0] rxSettings;
      logic [7:0] termPulse1;
      logic [7:0] termPulse2;
      logic [7:0] rdData;
      logic       rdValid;
   } srs_state_t;
endpackage

// [rtl/srs_route_ctrl.sv]
// control register bank and routing decode for the four-source link switch
`timescale 1ns/1ps
`default_nettype none

module srs_route_ctrl (
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire srs_pkg::srs_req_t        req,
   output logic [7:0]                    rdData,
   output logic                          rdValid,
   output logic                          fastActive,
   output logic [1:0]                    fastSwitchingMode,
   output logic [3:0]                    fastSourceSelect,
   output logic [15:0]                   fastSingleSel,
   output logic [1:0]                    sideSwitchingMode,
   output srs_pkg::srs_side_route_t      sideRoute,
   output logic                          termOn,
   output logic [15:0]                   termPulseSelect
);
   import srs_pkg::*;

   srs_state_t state_q;
   srs_state_t state_d;
   logic [1:0] sideMode;
   logic [3:0] sideSrc;
   logic       sideEnable;

   ////////////////////////////////////////////////////////////////////////////
   // register bank

   // a mode field holds its old value when the illegal code arrives, so a
   // bad write cannot leave the switch in an undefined bundling
   function automatic logic [7:0] merge_modes(input logic [7:0] oldV, input logic [7:0] newV);
      logic [7:0] r;
      r = newV & SRS_MASK_MODES;
      if (newV[SRS_MODE_MSB:SRS_MODE_LSB] == SRS_MODE_ILLEGAL) begin
         r[SRS_MODE_MSB:SRS_MODE_LSB] = oldV[SRS_MODE_MSB:SRS_MODE_LSB];
      end
      return r;
   endfunction

   // next state: writes land in one cycle, reads answer one cycle later
   always_comb begin
      state_d = state_q;
      state_d.rdValid = req.rdEn;
      if (req.wrEn) begin
         case (req.addr)
            SRS_OFS_FAST_MODES: begin
               state_d.fastModes = merge_modes(state_q.fastModes, req.wrData);
            end
            SRS_OFS_SIDE_MODES: begin
               state_d.sideModes = merge_modes(state_q.sideModes, req.wrData);
            end
            SRS_OFS_RX_SETTINGS: begin
               state_d.rxSettings = req.wrData & SRS_MASK_RX;
            end
            SRS_OFS_TERM_PULSE1: begin
               state_d.termPulse1 = req.wrData & SRS_MASK_PULSE;
            end
            SRS_OFS_TERM_PULSE2: begin
               state_d.termPulse2 = req.wrData & SRS_MASK_PULSE;
            end
            default: begin
               state_d.rdValid = req.rdEn; // unmapped writes are dropped
            end
         endcase
      end
      if (req.rdEn) begin
         case (req.addr)
            SRS_OFS_FAST_MODES:  state_d.rdData = state_q.fastModes;
            SRS_OFS_SIDE_MODES:  state_d.rdData = state_q.sideModes;
            SRS_OFS_RX_SETTINGS: state_d.rdData = state_q.rxSettings;
            SRS_OFS_TERM_PULSE1: state_d.rdData = state_q.termPulse1;
            SRS_OFS_TERM_PULSE2: state_d.rdData = state_q.termPulse2;
            default:             state_d.rdData = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= '{fastModes:  SRS_RST_FAST_MODES,
                      sideModes:  SRS_RST_SIDE_MODES,
                      rxSettings: SRS_RST_RX_SETTINGS,
                      termPulse1: SRS_RST_TERM_PULSE,
                      termPulse2: SRS_RST_TERM_PULSE,
                      rdData:     8'h00,
                      rdValid:    1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // routing decode straight from the stored fields, no extra latency

   assign rdData            = state_q.rdData;
   assign rdValid           = state_q.rdValid;
   assign fastActive        = state_q.fastModes[SRS_ENABLE_BIT];
   assign fastSwitchingMode = state_q.fastModes[SRS_MODE_MSB:SRS_MODE_LSB];
   assign fastSourceSelect  = state_q.fastModes[SRS_SRC_MSB:SRS_SRC_LSB];
   assign sideEnable        = state_q.sideModes[SRS_ENABLE_BIT];
   assign sideMode          = state_q.sideModes[SRS_MODE_MSB:SRS_MODE_LSB];
   assign sideSrc           = state_q.sideModes[SRS_SRC_MSB:SRS_SRC_LSB];
   assign sideSwitchingMode = sideMode;
   assign termOn            = state_q.rxSettings[SRS_TERM_BIT];
   // pulse bits only matter while terminations are on
   assign termPulseSelect   = termOn ? {state_q.termPulse2, state_q.termPulse1} : 16'h0000;

   // single fast mode: one-hot over A0..D3, index = {source, channel}
   always_comb begin
      fastSingleSel = 16'h0000;
      if (fastActive && fastSwitchingMode == SRS_MODE_SINGLE) begin
         fastSingleSel[fastSourceSelect] = 1'b1;
      end
   end

   // side switch: chanSel is {source[1:0], channel[1:0]} for each common line
   always_comb begin
      sideRoute = '0;
      if (sideEnable) begin
         case (sideMode)
            SRS_MODE_QUAD: begin
               for (int i = 0; i < SRS_LINES; i++) begin
                  sideRoute.connect[i] = 1'b1;
                  sideRoute.chanSel[i] = {sideSrc[1:0], 2'(i)};
               end
            end
            SRS_MODE_DUAL: begin
               for (int i = 0; i < SRS_LINES; i++) begin
                  sideRoute.connect[i] = 1'b1;
               end
               // lines 1:0 take A or B, lines 3:2 take C or D
               sideRoute.chanSel[0] = {1'b0, sideSrc[2], sideSrc[1:0]};
               sideRoute.chanSel[1] = {1'b0, sideSrc[2], sideSrc[1:0]};
               sideRoute.chanSel[2] = {1'b1, sideSrc[2], sideSrc[1:0]};
               sideRoute.chanSel[3] = {1'b1, sideSrc[2], sideSrc[1:0]};
            end
            SRS_MODE_SINGLE: begin
               sideRoute.connect[0] = 1'b1;
               sideRoute.chanSel[0] = sideSrc;
            end
            default: begin
               sideRoute = '0; // illegal code is never stored
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // a modes write that carries the illegal mode code
   sequence seq_side_bad_wr;
      req.wrEn && req.addr == SRS_OFS_SIDE_MODES
         && req.wrData[SRS_MODE_MSB:SRS_MODE_LSB] == SRS_MODE_ILLEGAL;
   endsequence
   sequence seq_fast_bad_wr;
      req.wrEn && req.addr == SRS_OFS_FAST_MODES
         && req.wrData[SRS_MODE_MSB:SRS_MODE_LSB] == SRS_MODE_ILLEGAL;
   endsequence
   // a side modes write with a legal code; mode and source must land together
   sequence seq_side_good_wr;
      req.wrEn && req.addr == SRS_OFS_SIDE_MODES
         && req.wrData[SRS_MODE_MSB:SRS_MODE_LSB] != SRS_MODE_ILLEGAL;
   endsequence

   AST_FAST_SINGLE_ONEHOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (fastActive && fastSwitchingMode == SRS_MODE_SINGLE)
      |-> fastSingleSel == (16'h0001 << fastSourceSelect))
      else $error("fast single select wrong");
   AST_FAST_NOT_SINGLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
      fastSwitchingMode != SRS_MODE_SINGLE |-> fastSingleSel == 16'h0000)
      else $error("fast single select driven outside single mode");
   AST_SIDE_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !sideEnable |-> sideRoute.connect == 4'h0)
      else $error("side lines connected while disabled");
   AST_SIDE_MODE_LEGAL: assert property (@(posedge ref_clk) disable iff (!arst_n)
      sideMode != SRS_MODE_ILLEGAL && fastSwitchingMode != SRS_MODE_ILLEGAL)
      else $error("illegal mode stored");
   AST_SIDE_ILLEGAL_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_side_bad_wr |=> sideMode == $past(sideMode))
      else $error("side mode changed by illegal write");
   AST_SIDE_QUAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (sideEnable && sideMode == SRS_MODE_QUAD) |->
      (sideRoute.connect == 4'hf && sideRoute.chanSel[3] == {sideSrc[1:0], 2'h3}))
      else $error("side quad routing wrong");
   AST_SIDE_DUAL: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (sideEnable && sideMode == SRS_MODE_DUAL) |->
      (sideRoute.chanSel[0] == {1'b0, sideSrc[2:0]}
         && sideRoute.chanSel[2] == {1'b1, sideSrc[2:0]}))
      else $error("side dual routing wrong");
   AST_SIDE_SINGLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (sideEnable && sideMode == SRS_MODE_SINGLE) |->
      (sideRoute.connect == 4'h1 && sideRoute.chanSel[0] == sideSrc))
      else $error("side single routing wrong");
   AST_TERM_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !termOn |-> termPulseSelect == 16'h0000)
      else $error("pulse select active with terminations off");
   AST_FAST_ILLEGAL_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_fast_bad_wr |=> fastSwitchingMode == $past(fastSwitchingMode)
         && fastSourceSelect == $past(req.wrData[SRS_SRC_MSB:SRS_SRC_LSB]))
      else $error("fast mode changed by illegal write");
   AST_FAST_STANDBY: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !fastActive |-> fastSingleSel == 16'h0000)
      else $error("fast path routed in standby");
   AST_WRITE_APPLIES: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (req.wrEn && req.addr == SRS_OFS_RX_SETTINGS)
      |=> termOn == $past(req.wrData[SRS_TERM_BIT]))
      else $error("write not applied next cycle");
   AST_SIDE_WRITE_APPLIES: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_side_good_wr |=> sideMode == $past(req.wrData[SRS_MODE_MSB:SRS_MODE_LSB])
         && sideSrc == $past(req.wrData[SRS_SRC_MSB:SRS_SRC_LSB]))
      else $error("side mode write not applied next cycle");
endmodule
`default_nettype wire

// [dv/srs_host_model.sv]
// host model driving the register request port
`timescale 1ns/1ps
`default_nettype none
module srs_host_model (
   input  wire logic          ref_clk,
   output var srs_pkg::srs_req_t req,
   input  wire logic [7:0]    rdData,
   input  wire logic          rdValid
);
   import srs_pkg::*;
   initial req = '0;
   ////////////////////////////////////////////////////////////
   // one write: strobe held across the taking edge only
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req.wrEn   <= 1'b1;
      req.addr   <= a;
      req.wrData <= d;
      @(posedge ref_clk);
      req.wrEn   <= 1'b0;
      req.addr   <= ~a; // scramble stale fields once released
      req.wrData <= ~d;
      #1;
   endtask
   // one read: data taken only while rdValid stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      req.rdEn <= 1'b1;
      req.addr <= a;
      @(posedge ref_clk);
      req.rdEn <= 1'b0;
      req.addr <= ~a;
      #1;
      d = rdValid ? rdData : 8'hxx; // missing answer never matches
   endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the route select control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import srs_pkg::*;
   logic            ref_clk = 1'b0;
   logic            arst_n = 1'b0;
   srs_req_t        req;
   logic [7:0]      rdData, r;
   logic            rdValid, fastActive, termOn;
   logic [1:0]      fastSwitchingMode, sideSwitchingMode;
   logic [3:0]      fastSourceSelect;
   logic [15:0]     fastSingleSel, termPulseSelect;
   srs_side_route_t sideRoute;
   int              n_errors = 0;
   int              cmp_count = 0;
   logic [7:0]      ofs [5] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12};
   logic [7:0]      rst [5] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00};
   always #25 ref_clk = ~ref_clk;
   srs_route_ctrl u_srs_route_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
      .req(req), .rdData(rdData), .rdValid(rdValid), .fastActive(fastActive),
      .fastSwitchingMode(fastSwitchingMode), .fastSourceSelect(fastSourceSelect),
      .fastSingleSel(fastSingleSel), .sideSwitchingMode(sideSwitchingMode),
      .sideRoute(sideRoute), .termOn(termOn), .termPulseSelect(termPulseSelect));
   srs_host_model u_srs_host_model (.ref_clk(ref_clk), .req(req),
      .rdData(rdData), .rdValid(rdValid));
   ////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected side routing, worked out per common line
   function automatic srs_side_route_t side_exp(input logic [1:0] m, input logic [3:0] k);
      srs_side_route_t e;
      e = '0;
      for (int i = 0; i < 4; i++) begin
         e.connect[i] = (m != SRS_MODE_SINGLE) || (i == 0);
         case (m)
            SRS_MODE_QUAD: e.chanSel[i] = {k[1:0], i[1:0]};
            SRS_MODE_DUAL: e.chanSel[i] = {i[1], k[2:0]};
            default:       e.chanSel[i] = (i == 0) ? k : 4'h0;
         endcase
      end
      return e;
   endfunction
   task automatic give_verdict();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // watchdog: 5000 cycles, far beyond the fewer than two hundred cycles the tests need
   initial begin
      #(50 * 5000);
      n_errors++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      // reset values, then an unmapped read
      for (int i = 0; i < 5; i++) begin
         u_srs_host_model.rd(ofs[i], r);
         chk(r, rst[i]);
      end
      u_srs_host_model.rd(8'h33, r);
      chk(r, 8'h00);
      chk(sideRoute, side_exp(SRS_MODE_QUAD, 4'h0));
      // every fast single code, applied right after its write
      for (int k = 0; k < 16; k++) begin
         u_srs_host_model.wr(SRS_OFS_FAST_MODES, {4'h6, 4'(k)});
         chk(fastSingleSel, 32'(1) << k);
      end
      u_srs_host_model.wr(SRS_OFS_FAST_MODES, 8'h75);
      chk({fastSwitchingMode, fastSourceSelect, fastSingleSel}, 32'h25_0020);
      u_srs_host_model.wr(SRS_OFS_FAST_MODES, 8'h25);
      chk({fastActive, fastSingleSel}, 32'h0);
      // dual and quad fast modes store but route nothing on the single path
      u_srs_host_model.wr(SRS_OFS_FAST_MODES, 8'hd9);
      chk({fastActive, fastSwitchingMode, fastSourceSelect, fastSingleSel}, 32'h59_0000);
      u_srs_host_model.rd(SRS_OFS_FAST_MODES, r);
      chk(r, 8'h59);
      u_srs_host_model.wr(SRS_OFS_FAST_MODES, 8'h4e);
      chk({fastActive, fastSwitchingMode, fastSourceSelect, fastSingleSel}, 32'h4e_0000);
      // every side mode with every source code
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 16; k++) begin
            u_srs_host_model.wr(SRS_OFS_SIDE_MODES, {2'b01, 2'(m), 4'(k)});
            chk(sideSwitchingMode, 32'(m));
            chk(sideRoute, side_exp(2'(m), 4'(k)));
         end
      end
      // illegal mode keeps single; source still updates
      u_srs_host_model.wr(SRS_OFS_SIDE_MODES, 8'h73);
      chk(sideRoute, side_exp(SRS_MODE_SINGLE, 4'h3));
      u_srs_host_model.wr(SRS_OFS_SIDE_MODES, 8'h13);
      chk(sideRoute, 32'h0);
      u_srs_host_model.rd(SRS_OFS_SIDE_MODES, r);
      chk(r, 8'h13);
      // termination on with pulse selects, then off
      u_srs_host_model.wr(SRS_OFS_TERM_PULSE1, 8'ha5);
      u_srs_host_model.wr(SRS_OFS_TERM_PULSE2, 8'h3c);
      chk({termOn, termPulseSelect}, 32'h1_3ca5);
      u_srs_host_model.wr(SRS_OFS_RX_SETTINGS, 8'hff);
      u_srs_host_model.rd(SRS_OFS_RX_SETTINGS, r);
      chk(r, 8'h01);
      u_srs_host_model.wr(SRS_OFS_RX_SETTINGS, 8'h00);
      chk({termOn, termPulseSelect}, 32'h0);
      // mid-run reset must act before any clock edge
      @(posedge ref_clk);
      arst_n <= 1'b0;
      #1;
      chk({termOn, fastActive, sideRoute}, {2'b11, side_exp(SRS_MODE_QUAD, 4'h0)});
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      u_srs_host_model.rd(SRS_OFS_FAST_MODES, r);
      chk(r, 8'h40);
      give_verdict();
   end
endmodule
`default_nettype wire
